// [verilog/sprb_bank.v]
/*
 * special purpose register bank: link, loop count, fixed point exception,
 * time base, decrementer, exception save/restore, fault, scratch,
 * version, tag, external access control and address breakpoints.
 * assumes one clock (the bus clock), synchronous inputs, and an issuing
 * pipeline that presents one move request at a time and the privilege.
 */
// How it works
// - move port reaches every register; implicit updates too
// - 64-bit link register captures return address
// - loop count decrements, then tests for branch
// - 32-bit register records carry and overflow
// - time base readable by user, supervisor writes
// - listed supervisor registers need supervisor privilege
// - 32-bit countdown raises exception after delay
// - counters advance on the bus clock
// - 64-bit time base, halves, carry into upper
// - time base counts only while enable asserted
// - exception saves address; return resumes there
// - exception saves status; return restores it
// - fault address loaded on alignment/storage fault
// - fault cause recorded in 32-bit register
// - read-only version register ignores writes
// - right-justified 4-bit processor tag
// - access control gates external control words
// - instruction address match raises breakpoint
// - data address match raises breakpoint
// - four 64-bit scratch registers, no side effects
`timescale 1ns/1ps
`include "sprb_regs.vh"

module sprb_bank #(
	parameter [31:0] VERSION_ID = 32'h0001_0001 // arbitrary neutral value
) (
	input  wire                   clk_in,           // bus clock
	input  wire                   rst_in,           // async reset, high
	input  wire                   supervisor_in,    // 1 = supervisor privilege
	input  wire                   mov_wr_in,        // move-to request
	input  wire                   mov_rd_in,        // move-from request
	input  wire [`SPRB_IDX_W-1:0] mov_idx_in,       // register index
	input  wire [63:0]            mov_wdata_in,     // move-to data
	input  wire                   link_wr_in,       // branch-and-link executes
	input  wire [63:0]            link_addr_in,     // return address
	input  wire                   count_dec_in,     // branch-and-count executes
	input  wire                   xer_upd_in,       // arithmetic result flags valid
	input  wire                   carry_in,         // integer carry
	input  wire                   ovf_in,           // integer overflow
	input  wire                   time_count_enable_in, // time base enable
	input  wire                   exc_take_in,      // exception taken
	input  wire [63:0]            exc_addr_in,      // faulting/resume address
	input  wire [63:0]            exc_status_in,    // machine status to save
	input  wire                   rfi_in,           // return from interrupt
	input  wire                   fault_upd_in,     // alignment/storage fault
	input  wire [63:0]            fault_ea_in,      // offending address
	input  wire [31:0]            fault_cause_in,   // fault cause word
	input  wire                   dec_ack_in,       // decrementer exception taken
	input  wire                   iaddr_valid_in,   // instruction executing
	input  wire [63:0]            iaddr_in,         // its address
	input  wire                   daddr_valid_in,   // data access
	input  wire [63:0]            daddr_in,         // its address
	output reg  [63:0]            mov_rdata_out,    // move-from data
	output reg                    mov_ack_out,      // request completed
	output reg                    priv_fault_out,   // privileged program exception
	output reg  [63:0]            branch_link_out,  // branch target source
	output reg                    count_nonzero_out,// loop count nonzero after decrement
	output reg                    resume_out,       // pulse: resume now
	output reg  [63:0]            resume_addr_out,  // address to resume at
	output reg  [63:0]            resume_status_out,// status to restore
	output reg                    dec_irq_out,      // pending decrementer request
	output reg                    ibrk_out,         // instruction breakpoint pulse
	output reg                    dbrk_out,         // data breakpoint pulse
	output reg                    ext_access_enable_out, // external control allowed
	output reg  [`SPRB_TAG_W-1:0] processor_tag_out // processor tag
);

	reg  [63:0] loop_count_q;              // loop count
	reg  [31:0] fixed_point_exception_q;   // carry/overflow
	reg  [63:0] free_running_time_q;       // time base, both halves
	reg  [31:0] fault_cause_q;             // fault cause
	reg  [63:0] fault_address_q;           // fault address
	reg  [31:0] countdown_timer_q;         // decrementer
	reg         dec_msb_q;                 // last decrementer msb
	reg  [31:0] page_table_format_q;       // page table format
	reg  [63:0] segment_table_base_q;      // segment table base
	reg  [31:0] external_access_control_q; // external access control
	reg  [63:0] instruction_breakpoint_q;  // instruction breakpoint
	reg  [63:0] data_breakpoint_q;         // data breakpoint
	reg  [63:0] os_scratch_q [0:`SPRB_SCRATCH_N-1]; // scratch array

	reg         sup_only;  // index needs supervisor
	reg         mapped;    // index exists
	reg  [63:0] rd_mux;    // read selection
	wire        mov_any;   // a move request
	wire        allowed;   // request passes privilege
	wire        wr_ok;     // write may take effect
	wire [31:0] dec_next;  // decrementer next value
	wire [63:0] ctr_next;  // loop count after decrement
	wire [4:0]  scr_off;   // index offset into the scratch block

	assign mov_any  = mov_wr_in | mov_rd_in;
	assign allowed  = supervisor_in | ~sup_only;
	assign wr_ok    = mov_wr_in & allowed;
	assign ctr_next = loop_count_q - 64'h1;
	assign scr_off  = mov_idx_in - `SPRB_SCRATCH_0; // wraps high below the block
	assign dec_next = (wr_ok && mov_idx_in == `SPRB_COUNTDOWN) ?
		mov_wdata_in[31:0] : countdown_timer_q - 32'h1;

	// decode privilege class and existence of the index
	always @*
	begin
		sup_only = 1'b1;
		mapped   = 1'b1;
		case (mov_idx_in)
			`SPRB_BRANCH_LINK, `SPRB_LOOP_COUNT, `SPRB_FIXED_EXC:
				sup_only = 1'b0;
			`SPRB_TIME_LOWER, `SPRB_TIME_UPPER:
				sup_only = mov_wr_in;
			`SPRB_FAULT_CAUSE, `SPRB_FAULT_ADDR, `SPRB_COUNTDOWN,
			`SPRB_PAGE_TABLE, `SPRB_SAVE_ADDR, `SPRB_SAVE_STATUS,
			`SPRB_EXT_ACCESS, `SPRB_VERSION, `SPRB_SEG_TABLE,
			`SPRB_PROC_TAG, `SPRB_INSTR_BRK, `SPRB_DATA_BRK:
				sup_only = 1'b1;
			default:
			begin
				// scratch block or nothing at all
				mapped = (scr_off[4:2] == 3'h0);
				sup_only = mapped;
			end
		endcase
	end

	// read data selection; unmapped indices read zero
	always @*
	begin
		rd_mux = `SPRB_RST_64;
		case (mov_idx_in)
			`SPRB_BRANCH_LINK: rd_mux = branch_link_out;
			`SPRB_LOOP_COUNT:  rd_mux = loop_count_q;
			`SPRB_FIXED_EXC:   rd_mux = {32'h0, fixed_point_exception_q};
			`SPRB_TIME_LOWER:  rd_mux = {32'h0, free_running_time_q[31:0]};
			`SPRB_TIME_UPPER:  rd_mux = {32'h0, free_running_time_q[63:32]};
			`SPRB_FAULT_CAUSE: rd_mux = {32'h0, fault_cause_q};
			`SPRB_FAULT_ADDR:  rd_mux = fault_address_q;
			`SPRB_COUNTDOWN:   rd_mux = {32'h0, countdown_timer_q};
			`SPRB_PAGE_TABLE:  rd_mux = {32'h0, page_table_format_q};
			`SPRB_SAVE_ADDR:   rd_mux = resume_addr_out;
			`SPRB_SAVE_STATUS: rd_mux = resume_status_out;
			`SPRB_EXT_ACCESS:  rd_mux = {32'h0, external_access_control_q};
			`SPRB_VERSION:     rd_mux = {32'h0, VERSION_ID};
			`SPRB_SEG_TABLE:   rd_mux = segment_table_base_q;
			`SPRB_PROC_TAG:    rd_mux = {60'h0, processor_tag_out};
			`SPRB_INSTR_BRK:   rd_mux = instruction_breakpoint_q;
			`SPRB_DATA_BRK:    rd_mux = data_breakpoint_q;
			default:
			begin
				if (mapped)
					rd_mux = os_scratch_q[scr_off[1:0]];
			end
		endcase
	end

	// move port answer: data, completion and privilege fault
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			mov_rdata_out  <= `SPRB_RST_64;
			mov_ack_out    <= 1'b0;
			priv_fault_out <= 1'b0;
		end
		else
		begin
			mov_ack_out    <= mov_any & allowed;
			priv_fault_out <= mov_any & ~allowed;
			// hold last data unless a permitted read
			if (mov_rd_in && allowed)
				mov_rdata_out <= rd_mux;
		end
	end

	// user-level registers: link, loop count, fixed point exception
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			branch_link_out         <= `SPRB_RST_64;
			loop_count_q            <= `SPRB_RST_64;
			fixed_point_exception_q <= `SPRB_RST_32;
			count_nonzero_out       <= 1'b0;
		end
		else
		begin
			// implicit updates take priority over a move
			if (link_wr_in)
				branch_link_out <= link_addr_in;
			else if (wr_ok && mov_idx_in == `SPRB_BRANCH_LINK)
				branch_link_out <= mov_wdata_in;
			if (count_dec_in)
			begin
				loop_count_q      <= ctr_next;
				count_nonzero_out <= ctr_next != 64'h0;
			end
			else if (wr_ok && mov_idx_in == `SPRB_LOOP_COUNT)
				loop_count_q <= mov_wdata_in;
			if (xer_upd_in)
			begin
				fixed_point_exception_q[`SPRB_XER_CA_BIT] <= carry_in;
				fixed_point_exception_q[`SPRB_XER_OV_BIT] <= ovf_in;
			end
			else if (wr_ok && mov_idx_in == `SPRB_FIXED_EXC)
				fixed_point_exception_q <= mov_wdata_in[31:0];
		end
	end

	// time base: one 64-bit counter on the bus clock
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			free_running_time_q <= `SPRB_RST_64;
		else if (wr_ok && mov_idx_in == `SPRB_TIME_LOWER)
			free_running_time_q[31:0] <= mov_wdata_in[31:0];
		else if (wr_ok && mov_idx_in == `SPRB_TIME_UPPER)
			free_running_time_q[63:32] <= mov_wdata_in[31:0];
		else if (time_count_enable_in)
			free_running_time_q <= free_running_time_q + 64'h1;
	end

	// decrementer and its held exception request
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			countdown_timer_q <= `SPRB_RST_DEC;
			dec_msb_q         <= 1'b1;
			dec_irq_out       <= 1'b0;
		end
		else
		begin
			countdown_timer_q <= dec_next;
			dec_msb_q         <= countdown_timer_q[31];
			// a new request wins over an acknowledge
			if (countdown_timer_q[31] && !dec_msb_q)
				dec_irq_out <= 1'b1;
			else if (dec_ack_in)
				dec_irq_out <= 1'b0;
		end
	end

	// exception save/restore and fault recording
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			resume_addr_out   <= `SPRB_RST_64;
			resume_status_out <= `SPRB_RST_64;
			resume_out        <= 1'b0;
			fault_address_q   <= `SPRB_RST_64;
			fault_cause_q     <= `SPRB_RST_32;
		end
		else
		begin
			resume_out <= rfi_in & ~exc_take_in;
			if (exc_take_in)
			begin
				resume_addr_out   <= exc_addr_in;
				resume_status_out <= exc_status_in;
			end
			else
			begin
				if (wr_ok && mov_idx_in == `SPRB_SAVE_ADDR)
					resume_addr_out <= mov_wdata_in;
				if (wr_ok && mov_idx_in == `SPRB_SAVE_STATUS)
					resume_status_out <= mov_wdata_in;
			end
			if (fault_upd_in)
			begin
				fault_address_q <= fault_ea_in;
				fault_cause_q   <= fault_cause_in;
			end
			else
			begin
				if (wr_ok && mov_idx_in == `SPRB_FAULT_ADDR)
					fault_address_q <= mov_wdata_in;
				if (wr_ok && mov_idx_in == `SPRB_FAULT_CAUSE)
					fault_cause_q <= mov_wdata_in[31:0];
			end
		end
	end

	// plain supervisor registers with no side effects
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			page_table_format_q       <= `SPRB_RST_32;
			segment_table_base_q      <= `SPRB_RST_64;
			external_access_control_q <= `SPRB_RST_32;
			processor_tag_out         <= {`SPRB_TAG_W{1'b0}};
			instruction_breakpoint_q  <= `SPRB_RST_64;
			data_breakpoint_q         <= `SPRB_RST_64;
			ext_access_enable_out     <= 1'b0;
		end
		else
		begin
			if (wr_ok)
			begin
				case (mov_idx_in)
					`SPRB_PAGE_TABLE: page_table_format_q  <= mov_wdata_in[31:0];
					`SPRB_SEG_TABLE:  segment_table_base_q <= mov_wdata_in;
					`SPRB_EXT_ACCESS:
						external_access_control_q <= mov_wdata_in[31:0];
					`SPRB_PROC_TAG:
						processor_tag_out <= mov_wdata_in[`SPRB_TAG_W-1:0];
					`SPRB_INSTR_BRK:  instruction_breakpoint_q <= mov_wdata_in;
					`SPRB_DATA_BRK:   data_breakpoint_q        <= mov_wdata_in;
					default:          page_table_format_q      <= page_table_format_q;
				endcase
			end
			// enable follows the control register one cycle later
			ext_access_enable_out <= external_access_control_q[`SPRB_EAC_EN_BIT];
		end
	end

	// os scratch registers, one per entry
	genvar gi;
	generate
		for (gi = 0; gi < `SPRB_SCRATCH_N; gi = gi + 1)
		begin : g_scratch
			always @(posedge clk_in or posedge rst_in)
			begin
				if (rst_in)
					os_scratch_q[gi] <= `SPRB_RST_64;
				else if (wr_ok && mov_idx_in == `SPRB_SCRATCH_0 + gi)
					os_scratch_q[gi] <= mov_wdata_in;
			end
		end
	endgenerate

	// address breakpoints: word compare when enabled
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ibrk_out <= 1'b0;
			dbrk_out <= 1'b0;
		end
		else
		begin
			ibrk_out <= iaddr_valid_in &
				instruction_breakpoint_q[`SPRB_BRK_EN_BIT] &
				(iaddr_in[63:2] == instruction_breakpoint_q[63:2]);
			dbrk_out <= daddr_valid_in &
				data_breakpoint_q[`SPRB_BRK_EN_BIT] &
				(daddr_in[63:2] == data_breakpoint_q[63:2]);
		end
	end

endmodule // sprb_bank

// [verilog/sprb_regs.vh]
/*
 * special register bank constants: register index numbers used by the
 * move-to/move-from port, field positions, widths and reset values.
 * assumes it is included by sprb_bank.v and the testbench top, by its bare name.
 */
`ifndef SPRB_REGS_VH
`define SPRB_REGS_VH

// register index width on the move port
`define SPRB_IDX_W        5
// user-level registers
`define SPRB_BRANCH_LINK  5'h00
`define SPRB_LOOP_COUNT   5'h01
`define SPRB_FIXED_EXC    5'h02
`define SPRB_TIME_LOWER   5'h03
`define SPRB_TIME_UPPER   5'h04
// supervisor-level registers
`define SPRB_FAULT_CAUSE  5'h05
`define SPRB_FAULT_ADDR   5'h06
`define SPRB_COUNTDOWN    5'h07
`define SPRB_PAGE_TABLE   5'h08
`define SPRB_SAVE_ADDR    5'h09
`define SPRB_SAVE_STATUS  5'h0a
`define SPRB_SCRATCH_0    5'h0b
`define SPRB_EXT_ACCESS   5'h0f
`define SPRB_VERSION      5'h10
`define SPRB_SEG_TABLE    5'h11
`define SPRB_PROC_TAG     5'h12
`define SPRB_INSTR_BRK    5'h13
`define SPRB_DATA_BRK     5'h14
// number of os scratch registers
`define SPRB_SCRATCH_N    4
// fixed point exception fields
`define SPRB_XER_OV_BIT   30
`define SPRB_XER_CA_BIT   29
// external access control enable bit
`define SPRB_EAC_EN_BIT   31
// breakpoint enable bit; compare covers bits 63..2
`define SPRB_BRK_EN_BIT   0
// processor tag width
`define SPRB_TAG_W        4
// reset values
`define SPRB_RST_64       64'h0000_0000_0000_0000
`define SPRB_RST_32       32'h0000_0000
`define SPRB_RST_DEC      32'hffff_ffff

`endif

// [bench/sprb_bank_checker.sv]
/* sprb_bank_checker: port timing relations of the special register bank.
   assumes one bus clock and an asynchronous active-high reset. */
`timescale 1ns/1ps
module sprb_bank_checker (
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic        supervisor_in,
	input wire logic        mov_wr_in,
	input wire logic        mov_rd_in,
	input wire logic [4:0]  mov_idx_in,
	input wire logic        link_wr_in,
	input wire logic [63:0] link_addr_in,
	input wire logic        exc_take_in,
	input wire logic [63:0] exc_addr_in,
	input wire logic [63:0] exc_status_in,
	input wire logic        rfi_in,
	input wire logic        dec_ack_in,
	input wire logic        iaddr_valid_in,
	input wire logic        daddr_valid_in,
	input wire logic        mov_ack_out,
	input wire logic        priv_fault_out,
	input wire logic [63:0] branch_link_out,
	input wire logic        resume_out,
	input wire logic [63:0] resume_addr_out,
	input wire logic [63:0] resume_status_out,
	input wire logic        dec_irq_out,
	input wire logic        ibrk_out,
	input wire logic        dbrk_out,
	input wire logic [3:0]  processor_tag_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// user move-to aimed at a supervisor-only index
	sequence s_user_sup_wr;
		mov_wr_in && !supervisor_in && (mov_idx_in inside {[5'h05:5'h14]});
	endsequence
	// return without a competing exception
	sequence s_rfi_alone;
		rfi_in && !exc_take_in;
	endsequence
	AST_USER_REFUSED: assert property (s_user_sup_wr |=> priv_fault_out && !mov_ack_out)
		else $error("user write not refused");
	AST_SUP_ACK: assert property ((mov_rd_in || mov_wr_in) && supervisor_in |=> mov_ack_out)
		else $error("supervisor move not acknowledged");
	AST_LINK: assert property (link_wr_in |=> branch_link_out == $past(link_addr_in))
		else $error("link address not captured");
	AST_SAVE: assert property (exc_take_in |=> resume_addr_out == $past(exc_addr_in)
		&& resume_status_out == $past(exc_status_in)) else $error("exception state not saved");
	AST_RESUME: assert property (s_rfi_alone |=> resume_out)
		else $error("no resume after return");
	AST_RESUME_CAUSE: assert property (resume_out |-> $past(rfi_in))
		else $error("resume without return");
	AST_DEC_HOLD: assert property (dec_irq_out && !dec_ack_in |=> dec_irq_out)
		else $error("decrementer request dropped");
	AST_IBRK: assert property (ibrk_out |-> $past(iaddr_valid_in))
		else $error("instruction breakpoint without access");
	AST_DBRK: assert property (dbrk_out |-> $past(daddr_valid_in))
		else $error("data breakpoint without access");
	AST_TAG_STABLE: assert property (!(mov_wr_in && supervisor_in && mov_idx_in == 5'h12)
		|=> $stable(processor_tag_out)) else $error("tag changed without write");
endmodule // sprb_bank_checker

bind sprb_bank sprb_bank_checker chk_i (.clk_in, .rst_in, .supervisor_in, .mov_wr_in,
	.mov_rd_in, .mov_idx_in, .link_wr_in, .link_addr_in, .exc_take_in, .exc_addr_in,
	.exc_status_in, .rfi_in, .dec_ack_in, .iaddr_valid_in, .daddr_valid_in, .mov_ack_out,
	.priv_fault_out, .branch_link_out, .resume_out, .resume_addr_out, .resume_status_out,
	.dec_irq_out, .ibrk_out, .dbrk_out, .processor_tag_out);

// [bench/sprb_bank_tb_top.sv]
/* sprb_bank_tb_top: directed scenarios for the special register bank.
   assumes sprb_regs.vh on the include path and the bound checker. */
`timescale 1ns/1ps
`include "sprb_regs.vh"
module sprb_bank_tb_top;
	localparam [31:0] VER = 32'h00c3_0002; // arbitrary version value
	logic        clk = 0, rst = 1, sup = 1, wr = 0, rd = 0;
	logic [4:0]  idx = 0;
	logic [63:0] wd = 0, la = 0, ea = 0, es = 0, fe = 0, ia = 0, da = 0;
	logic [31:0] fc = 0;
	logic        lw = 0, cd = 0, xu = 0, cy = 0, ov = 0, te = 0, et = 0;
	logic        rf = 0, fu = 0, dk = 0, iv = 0, dv = 0;
	wire  [63:0] rdat, blo, ra, rs;
	wire         ack, flt, cnz, res, dirq, ib, db, eae;
	wire  [3:0]  tag;
	int          fail_count = 0, comparisons = 0;
	always #5 clk = ~clk;
	sprb_bank #(.VERSION_ID(VER)) uut (.clk_in(clk), .rst_in(rst), .supervisor_in(sup),
		.mov_wr_in(wr), .mov_rd_in(rd), .mov_idx_in(idx), .mov_wdata_in(wd),
		.link_wr_in(lw), .link_addr_in(la), .count_dec_in(cd), .xer_upd_in(xu),
		.carry_in(cy), .ovf_in(ov), .time_count_enable_in(te), .exc_take_in(et),
		.exc_addr_in(ea), .exc_status_in(es), .rfi_in(rf), .fault_upd_in(fu),
		.fault_ea_in(fe), .fault_cause_in(fc), .dec_ack_in(dk), .iaddr_valid_in(iv),
		.iaddr_in(ia), .daddr_valid_in(dv), .daddr_in(da), .mov_rdata_out(rdat),
		.mov_ack_out(ack), .priv_fault_out(flt), .branch_link_out(blo),
		.count_nonzero_out(cnz), .resume_out(res), .resume_addr_out(ra),
		.resume_status_out(rs), .dec_irq_out(dirq), .ibrk_out(ib), .dbrk_out(db),
		.ext_access_enable_out(eae), .processor_tag_out(tag));
	// compare and count
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		comparisons++;
		if (s !== e)
		begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	// one move request; f is the expected refusal
	task automatic mov(input logic w, input logic s, input logic [4:0] i,
		input logic [63:0] d, input logic f);
		wr = w;
		rd = !w;
		sup = s;
		idx = i;
		wd = d;
		tick;
		wr = 0;
		rd = 0;
		chk({ack, flt}, f ? 2'b01 : 2'b10);
		tick;
	endtask
	// writable registers except time base, decrementer, tag and breakpoints, with user attempts between write and readback
	task automatic t_rw;
		logic [4:0]  l [14] = '{0, 1, 2, 5, 6, 8, 9, 10, 11, 12, 13, 14, 15, 17};
		logic [63:0] v;
		foreach (l[k])
		begin
			v = 64'h5a3c_0f00_0000_00a5 ^ k;
			if (l[k] inside {2, 5, 8, 15})
				v[63:32] = 0;
			mov(1, 1, l[k], v, 0);
			// user write: same value where allowed, inverse where refused
			mov(1, 0, l[k], (l[k] > 2) ? ~v : v, l[k] > 2);
			mov(0, 0, l[k], 64'h0, l[k] > 2);
			mov(0, 1, l[k], 64'h0, 0);
			chk(rdat, v);
		end
		mov(1, 1, `SPRB_VERSION, 64'h0, 0);
		mov(0, 1, `SPRB_VERSION, 64'h0, 0);
		chk(rdat, {32'h0, VER});
		mov(1, 1, 5'h1f, 64'h7, 0);
		mov(0, 1, 5'h1f, 64'h0, 0);
		chk(rdat, 64'h0);
	endtask
	// time base carry across halves, gated by enable
	task automatic t_time;
		mov(1, 1, `SPRB_TIME_LOWER, 64'hffff_fffe, 0);
		mov(1, 1, `SPRB_TIME_UPPER, 64'h5, 0);
		mov(1, 0, `SPRB_TIME_UPPER, 64'h0, 1);
		te = 1;
		repeat (3) tick;
		te = 0;
		mov(0, 0, `SPRB_TIME_UPPER, 64'h0, 0);
		chk(rdat, 64'h6);
		mov(0, 0, `SPRB_TIME_LOWER, 64'h0, 0);
		chk(rdat, 64'h1);
	endtask
	// implicit updates: link, count, carry, fault, exception, return
	task automatic t_impl;
		la = 64'h1234_5678_9abc_def0;
		lw = 1;
		tick;
		lw = 0;
		chk(blo, la);
		mov(1, 1, `SPRB_LOOP_COUNT, 64'h2, 0);
		cd = 1;
		tick;
		chk(cnz, 1);
		tick;
		cd = 0;
		chk(cnz, 0);
		cy = 1;
		xu = 1;
		tick;
		xu = 0;
		mov(0, 0, `SPRB_FIXED_EXC, 64'h0, 0);
		chk(rdat[30:29], 2'b01);
		fe = 64'hdead_0000_0000_0040;
		fc = 32'h0200_0000;
		fu = 1;
		tick;
		fu = 0;
		mov(0, 1, `SPRB_FAULT_ADDR, 64'h0, 0);
		chk(rdat, fe);
		mov(0, 1, `SPRB_FAULT_CAUSE, 64'h0, 0);
		chk(rdat, {32'h0, fc});
		ea = 64'h0000_0000_0000_0700;
		es = 64'h8000_0000_0000_9032;
		et = 1;
		tick;
		et = 0;
		rf = 1;
		tick;
		rf = 0;
		chk(res, 1);
		chk(ra, ea);
		chk(rs, es);
	endtask
	// decrementer loaded with zero wraps and raises a held request
	task automatic t_dec;
		mov(1, 1, `SPRB_COUNTDOWN, 64'h0, 0);
		chk(dirq, 0);
		tick;
		chk(dirq, 1);
		tick;
		dk = 1;
		tick;
		dk = 0;
		chk(dirq, 0);
	endtask
	// breakpoints, external access enable and processor tag
	task automatic t_brk;
		mov(1, 1, `SPRB_INSTR_BRK, 64'h1001, 0);
		mov(1, 1, `SPRB_DATA_BRK, 64'h2001, 0);
		ia = 64'h1000;
		iv = 1;
		da = 64'h2004;
		dv = 1;
		tick;
		chk({ib, db}, 2'b10);
		ia = 64'h1008;
		da = 64'h2000;
		tick;
		iv = 0;
		dv = 0;
		chk({ib, db}, 2'b01);
		mov(1, 1, `SPRB_EXT_ACCESS, 64'h8000_0000, 0);
		tick;
		chk(eae, 1);
		mov(1, 1, `SPRB_PROC_TAG, 64'h5, 0);
		chk(tag, 4'h5);
	endtask
	task automatic finish_test;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		#1 rst = 0;
		tick;
		t_rw;
		t_time;
		t_impl;
		t_dec;
		t_brk;
		finish_test;
	end
	// watchdog well beyond the roughly 170 cycles needed
	initial
	begin
		#50000;
		fail_count++;
		finish_test;
	end
endmodule // sprb_bank_tb_top
